// ---- rtl/tap_config_loader.sv ----
`timescale 1ns/10ps
`include "tap_config_params.svh"
module tap_config_loader
    import tap_config_pkg::*;
#(
    parameter int WORD_WIDTH = `CFG_WORD_WIDTH
) (
    // clock and reset
    input  wire logic                            core_clk,
    input  wire logic                            rst_n,
    // test access port pins
    input  wire logic                            tck,
    input  wire logic                            tms,
    input  wire logic                            tdi,
    output logic                                 tdo,
    output logic                                 tdo_oe_n,
    // configuration side
    output logic                                 config_clear,
    output logic                                 config_loading,
    output logic [WORD_WIDTH-1:0]                config_word,
    output logic                                 config_word_valid,
    output tap_config_pkg::tap_state_type        tap_state,
    output logic [`IR_WIDTH-1:0]                 active_instruction
);
    import tap_config_pkg::*;

    logic [1:0]            tck_sync;
    logic [1:0]            tms_sync;
    logic [1:0]            tdi_sync;
    logic                  tck_prev;
    logic                  tck_rise;
    logic                  tck_fall;
    logic [`IR_WIDTH-1:0]  ir_shift;
    logic [WORD_WIDTH-1:0] dr_shift;
    localparam int COUNT_WIDTH = $clog2(WORD_WIDTH);

    logic [COUNT_WIDTH-1:0] bit_count;
    logic [7:0]            clear_count;
    logic [2:0]            tms_high_run;
    logic                  tdo_bit;
    tap_state_type         next_tap_state;

    function automatic tap_state_type tap_next(input tap_state_type s, input logic m);
        unique case (s)
            TLR:    tap_next = m ? TLR    : RTI;
            RTI:    tap_next = m ? SEL_DR : RTI;
            SEL_DR: tap_next = m ? SEL_IR : CAP_DR;
            CAP_DR: tap_next = m ? EX1_DR : SH_DR;
            SH_DR:  tap_next = m ? EX1_DR : SH_DR;
            EX1_DR: tap_next = m ? UPD_DR : PA_DR;
            PA_DR:  tap_next = m ? EX2_DR : PA_DR;
            EX2_DR: tap_next = m ? UPD_DR : SH_DR;
            UPD_DR: tap_next = m ? SEL_DR : RTI;
            SEL_IR: tap_next = m ? TLR    : CAP_IR;
            CAP_IR: tap_next = m ? EX1_IR : SH_IR;
            SH_IR:  tap_next = m ? EX1_IR : SH_IR;
            EX1_IR: tap_next = m ? UPD_IR : PA_IR;
            PA_IR:  tap_next = m ? EX2_IR : PA_IR;
            EX2_IR: tap_next = m ? UPD_IR : SH_IR;
            UPD_IR: tap_next = m ? SEL_DR : RTI;
        endcase
    endfunction

    // pin synchronisers
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tck_sync <= 2'h0;
            tms_sync <= 2'h0;
            tdi_sync <= 2'h0;
            tck_prev <= 1'b0;
        end else begin
            tck_sync <= {tck_sync[0], tck};
            tms_sync <= {tms_sync[0], tms};
            tdi_sync <= {tdi_sync[0], tdi};
            tck_prev <= tck_sync[1];
        end
    end
    assign tck_rise = tck_sync[1] & ~tck_prev;
    assign tck_fall = ~tck_sync[1] & tck_prev;

    assign next_tap_state = tap_next(tap_state, tms_sync[1]);

    // tap controller
    always_ff @(posedge core_clk) begin
        if (!rst_n)
            tap_state <= TLR;
        else if (tck_rise)
            tap_state <= next_tap_state;
    end

    // run of tck rises with tms high, saturating
    always_ff @(posedge core_clk) begin
        if (!rst_n)
            tms_high_run <= 3'h0;
        else if (tck_rise && !tms_sync[1])
            tms_high_run <= 3'h0;
        else if (tck_rise && tms_high_run != 3'h7)
            tms_high_run <= tms_high_run + 3'h1;
    end

    // instruction register, new instruction takes effect on falling tck in update-ir
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ir_shift           <= `IR_CAPTURE;
            active_instruction <= `IR_BYPASS;
        end else if (tck_rise) begin
            unique case (tap_state)
                TLR: active_instruction <= `IR_BYPASS;
                CAP_IR: ir_shift <= `IR_CAPTURE;
                SH_IR: ir_shift <= {tdi_sync[1], ir_shift[`IR_WIDTH-1:1]};
                default: ;
            endcase
        end else if (tck_fall && tap_state == UPD_IR) begin
            active_instruction <= ir_shift;
        end
    end

    // configuration clear after the reprogram opcode
    always_ff @(posedge core_clk) begin
        if (!rst_n)
            clear_count <= 8'h0;
        else if (tck_fall && tap_state == UPD_IR && ir_shift == `IR_REPROGRAM)
            clear_count <= 8'(`CLEAR_CYCLES);
        else if (clear_count != 8'h0)
            clear_count <= clear_count - 8'h1;
    end
    assign config_clear = (clear_count != 8'h0);
    assign config_loading = (active_instruction == `IR_CONFIG_IN);

    // bitstream data path, msb first
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            dr_shift          <= '0;
            bit_count         <= '0;
            config_word       <= '0;
            config_word_valid <= 1'b0;
        end else begin
            config_word_valid <= 1'b0;
            if (tck_rise && config_loading) begin
                if (tap_state == CAP_DR)
                    bit_count <= '0;
                else if (tap_state == SH_DR) begin
                    dr_shift <= {dr_shift[WORD_WIDTH-2:0], tdi_sync[1]};
                    bit_count <= bit_count + 1'b1;
                    if (bit_count == COUNT_WIDTH'(WORD_WIDTH - 1)) begin
                        config_word       <= {dr_shift[WORD_WIDTH-2:0], tdi_sync[1]};
                        config_word_valid <= 1'b1;
                    end
                end
            end
        end
    end

    // tdo changes on falling tck
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tdo      <= 1'b0;
            tdo_oe_n <= 1'b1;
        end else if (tck_fall) begin
            tdo      <= tdo_bit;
            tdo_oe_n <= !(tap_state == SH_IR || tap_state == SH_DR);
        end
    end
    assign tdo_bit = (tap_state == SH_IR) ? ir_shift[0] : dr_shift[WORD_WIDTH-1];

    property p_tlr_five;
        @(posedge core_clk) disable iff (!rst_n)
        (tms_high_run >= 3'h5) |-> tap_state == TLR;
    endproperty
    a_tlr_five: assert property (p_tlr_five) else $error("no test-logic-reset");
    property p_tap_reset_from_ir;
        @(posedge core_clk) disable iff (!rst_n)
        (tck_rise && tap_state == SEL_IR && tms_sync[1]) |=> tap_state == TLR;
    endproperty
    a_tap_reset_from_ir: assert property (p_tap_reset_from_ir) else $error("no reset");
    property p_shift_ir_entry;
        @(posedge core_clk) disable iff (!rst_n)
        (tck_rise && tap_state == CAP_IR && !tms_sync[1]) |=> tap_state == SH_IR;
    endproperty
    a_shift_ir_entry: assert property (p_shift_ir_entry) else $error("no shift-ir");
    property p_ir_update;
        @(posedge core_clk) disable iff (!rst_n)
        (tck_fall && tap_state == UPD_IR) |=> active_instruction == $past(ir_shift);
    endproperty
    a_ir_update: assert property (p_ir_update) else $error("ir not loaded");
    property p_clear;
        @(posedge core_clk) disable iff (!rst_n)
        (tck_fall && tap_state == UPD_IR && ir_shift == `IR_REPROGRAM)
            |=> config_clear [*8];
    endproperty
    a_clear: assert property (p_clear) else $error("clear too short");
    property p_ir_shift_lsb;
        @(posedge core_clk) disable iff (!rst_n)
        (tck_rise && tap_state == SH_IR) |=> ir_shift[`IR_WIDTH-1] == $past(tdi_sync[1]);
    endproperty
    a_ir_shift_lsb: assert property (p_ir_shift_lsb) else $error("ir shift");
    property p_dr_shift_msb;
        @(posedge core_clk) disable iff (!rst_n)
        (tck_rise && tap_state == SH_DR && config_loading)
            |=> dr_shift[0] == $past(tdi_sync[1]);
    endproperty
    a_dr_shift_msb: assert property (p_dr_shift_msb) else $error("dr shift");
    property p_last_bit;
        @(posedge core_clk) disable iff (!rst_n)
        (tck_rise && tap_state == SH_DR && tms_sync[1]) |=> tap_state == EX1_DR;
    endproperty
    a_last_bit: assert property (p_last_bit) else $error("no exit1-dr");
    property p_word_only_loading;
        @(posedge core_clk) disable iff (!rst_n)
        config_word_valid |-> $past(config_loading) && $past(tap_state) == SH_DR;
    endproperty
    a_word_only_loading: assert property (p_word_only_loading) else $error("stray word");
    property p_tdo_idle;
        @(posedge core_clk) disable iff (!rst_n)
        (tck_fall && tap_state == RTI) |=> tdo_oe_n;
    endproperty
    a_tdo_idle: assert property (p_tdo_idle) else $error("tdo driven");
    c_reprogram: cover property (@(posedge core_clk) disable iff (!rst_n) config_clear);
    c_loading: cover property (@(posedge core_clk) disable iff (!rst_n) config_loading);
    c_word: cover property (@(posedge core_clk) disable iff (!rst_n) config_word_valid);
    c_exit_dr: cover property (@(posedge core_clk) disable iff (!rst_n) tap_state == EX1_DR);
endmodule // tap_config_loader

// ---- rtl/tap_config_params.svh ----
`ifndef TAP_CONFIG_PARAMS_SVH
`define TAP_CONFIG_PARAMS_SVH
`define IR_WIDTH            6
`define IR_REPROGRAM        6'h0b
`define IR_CONFIG_IN        6'h05
`define IR_BYPASS           6'h3f
`define IR_CAPTURE          6'h01
`define CFG_WORD_WIDTH      32
`define CLEAR_TIME_NS       50
`define CORE_CLK_PERIOD_NS  5
`define CLEAR_CYCLES        ((`CLEAR_TIME_NS + `CORE_CLK_PERIOD_NS - 1) / `CORE_CLK_PERIOD_NS)
`endif

// ---- rtl/tap_config_pkg.sv ----
package tap_config_pkg;
    typedef enum logic [3:0] {
        TLR = 4'h0, RTI = 4'h1, SEL_DR = 4'h2, CAP_DR = 4'h3,
        SH_DR = 4'h4, EX1_DR = 4'h5, PA_DR = 4'h6, EX2_DR = 4'h7,
        UPD_DR = 4'h8, SEL_IR = 4'h9, CAP_IR = 4'ha, SH_IR = 4'hb,
        EX1_IR = 4'hc, PA_IR = 4'hd, EX2_IR = 4'he, UPD_IR = 4'hf
    } tap_state_type;
endpackage

// ---- verification/tap_host_model.sv ----
`timescale 1ns/10ps
module tap_host_model (
    // clock
    input  wire logic core_clk,
    // test access port pins
    output logic      tck,
    output logic      tms,
    output logic      tdi
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // one 80 ns tck cycle; tms and tdi change with falling tck, tck low between cycles
    task automatic step(input logic t_ms, input logic t_di);
        tms = t_ms;
        tdi = t_di;
        repeat (8) @(negedge core_clk);
        tck = 1'b1;
        repeat (8) @(negedge core_clk);
        tck = 1'b0;
    endtask
    // tms walk, lsb of pattern first; tdi unused so it shows its inverse
    task automatic walk(input logic [7:0] pat, input int n);
        for (int i = 0; i < n; i++) begin
            step(pat[i], ~tdi);
        end
    endtask
    // opcode lsb first, msb leaves shift-ir with tms high
    task automatic load_ir(input logic [5:0] op);
        for (int i = 0; i < 6; i++) begin
            step(i == 5, op[i]);
        end
    endtask
    // word msb first, bit 0 may leave shift-dr
    task automatic load_dr(input logic [31:0] w, input logic last);
        for (int i = 31; i >= 0; i--) begin
            step(last && i == 0, w[i]);
        end
    endtask
endmodule // tap_host_model

// ---- verification/jtag_config_load_sequence_tb.sv ----
`timescale 1ns/10ps
`include "tap_config_params.svh"
module jtag_config_load_sequence_tb;
    import tap_config_pkg::*;
    logic          core_clk;
    logic          rst_n;
    logic          tck;
    logic          tms;
    logic          tdi;
    logic          tdo;
    logic          tdo_oe_n;
    logic          config_clear;
    logic          config_loading;
    logic [31:0]   config_word;
    logic          config_word_valid;
    tap_state_type tap_state;
    logic [5:0]    active_instruction;
    int            n_fail;
    int            checks_done;
    int            clear_len;
    logic [31:0]   seed;
    logic [31:0]   w;
    logic [31:0]   got[$];
    logic [31:0]   exp_q[$];

    tap_config_loader #(.WORD_WIDTH(32)) u_dut (.core_clk(core_clk), .rst_n(rst_n),
        .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
        .config_clear(config_clear), .config_loading(config_loading),
        .config_word(config_word), .config_word_valid(config_word_valid),
        .tap_state(tap_state), .active_instruction(active_instruction));
    tap_host_model u_host (.core_clk(core_clk), .tck(tck), .tms(tms), .tdi(tdi));

    function automatic logic [31:0] next_rand(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // collect words and clear length
    always @(posedge core_clk) begin
        if (config_word_valid === 1'b1) got.push_back(config_word);
        if (config_clear === 1'b1) clear_len++;
    end

    initial begin
        repeat (100000) @(posedge core_clk);
        n_fail++;
        $display("ERROR at %0t: run timed out", $time);
        complete_run();
    end

    initial begin
        rst_n = 1'b0;
        n_fail = 0;
        checks_done = 0;
        clear_len = 0;
        seed = 32'h11;
        repeat (2) @(negedge core_clk);
        rst_n = 1'b1;
        check(tap_state, TLR);
        check(active_instruction, `IR_BYPASS);
        check(tdo_oe_n, 1'b1);
        u_host.walk(8'h1f, 6);
        check(tap_state, RTI);
        u_host.walk(8'h03, 4);
        check(tap_state, SH_IR);
        repeat (4) @(negedge core_clk);
        check(tdo_oe_n, 1'b0);
        check(tdo, `IR_CAPTURE & 6'h01);
        u_host.load_ir(`IR_REPROGRAM);
        check(tap_state, EX1_IR);
        u_host.walk(8'h01, 1);
        repeat (20) @(negedge core_clk);
        check(active_instruction, `IR_REPROGRAM);
        check(clear_len, `CLEAR_CYCLES);
        $display("test reprogram done");
        u_host.walk(8'h1f, 5);
        check(active_instruction, `IR_BYPASS);
        u_host.walk(8'h00, 16);
        // data with the bypass instruction loads nothing
        u_host.walk(8'h01, 3);
        u_host.load_dr(next_rand(seed), 1'b1);
        u_host.walk(8'h01, 2);
        check(got.size(), 0);
        $display("test refused data done");
        u_host.walk(8'h03, 4);
        u_host.load_ir(`IR_CONFIG_IN);
        u_host.walk(8'h03, 4);
        check(config_loading, 1'b1);
        check(tap_state, SH_DR);
        for (int k = 0; k < 4; k++) begin
            seed = next_rand(seed);
            w = (k == 0) ? 32'h80000001 : seed;
            exp_q.push_back(w);
            u_host.load_dr(w, k == 3);
        end
        check(tap_state, EX1_DR);
        u_host.walk(8'h01, 2);
        check(tap_state, RTI);
        check(got.size(), 4);
        foreach (exp_q[i]) check(got[i], exp_q[i]);
        $display("test bitstream done");
        complete_run();
    end
endmodule // jtag_config_load_sequence_tb
